// File: include/gpp_pkg.sv
package gpp_pkg;
	localparam int          NUM_PORTS   = 9;
	localparam int          PORT_W      = 8;
	localparam int          ADDR_W      = 12;
	localparam int          NUM_OD      = 9;
	localparam int          NUM_TIMER   = 4;
	// port indices, in pin-group order
	localparam int          PORT_A      = 0;
	localparam int          PORT_B      = 1;
	localparam int          PORT_C      = 2;
	localparam int          PORT_D      = 3;
	localparam int          PORT_E      = 4;
	localparam int          PORT_F      = 5;
	localparam int          PORT_G      = 6;
	localparam int          PORT_H      = 7;
	localparam int          PORT_J      = 8;
	// byte addresses
	localparam logic [11:0] LEVEL_BASE  = 12'h000;
	localparam logic [11:0] LATCH_BASE  = 12'h040;
	localparam logic [11:0] DIR_BASE    = 12'h080;
	localparam logic [11:0] INT_CTRL2   = 12'h0c0;
	localparam logic [11:0] WDT_CTRL    = 12'h0c4;
	localparam logic [11:0] SH_ODC1     = 12'h0c8;
	localparam logic [11:0] SH_ODC2     = 12'h0cc;
	localparam logic [11:0] SH_ODC3     = 12'h0d0;
	localparam logic [11:0] SH_PADCFG   = 12'h0d4;
	localparam logic [11:0] BANK_SPAN   = 12'h024;
	// field positions
	localparam int          FIRST_PU_BIT = 7;
	localparam int          SEVENTH_PU_HI = 7;
	localparam int          SEVENTH_PU_LO = 5;
	localparam int          SHARED_SEL_BIT = 4;
	localparam int          PAD_TTL_BIT  = 0;
	// implemented-bit masks
	localparam logic [7:0]  ODC1_MASK   = 8'h1f;
	localparam logic [7:0]  ODC2_MASK   = 8'h03;
	localparam logic [7:0]  ODC3_MASK   = 8'h03;
	localparam logic [7:0]  PADCFG_MASK = 8'h01;
	// reset values
	localparam logic [7:0]  DIR_RST     = 8'hff;
	localparam logic [7:0]  LATCH_RST   = 8'h00;
	localparam logic [7:0]  CTRL_RST    = 8'h00;
	// open-drain pin map: enh1,enh2,enh3,cc4,cc5,tx1,tx2,sdo1,sdo2
	localparam int          OD_PORT [NUM_OD] = '{2, 2, 6, 6, 6, 2, 6, 2, 3};
	localparam int          OD_BIT  [NUM_OD] = '{2, 1, 0, 3, 4, 6, 1, 5, 4};

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} gpp_apb_req_s;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} gpp_apb_rsp_s;

	typedef struct packed {
		logic [PORT_W-1:0] en;
		logic [PORT_W-1:0] dout;
		logic [PORT_W-1:0] oe;
	} gpp_periph_s;

	typedef struct packed {
		logic [PORT_W-1:0] dout;
		logic [PORT_W-1:0] oe;
		logic [PORT_W-1:0] pull;
	} gpp_pad_s;
endpackage : gpp_pkg

// File: design/gpp_port.sv
`timescale 1ns/1ps
module gpp_port
	import gpp_pkg::*;
(
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	input  wire logic [PORT_W-1:0]    dir,
	input  wire logic [PORT_W-1:0]    latch,
	input  wire gpp_pkg::gpp_periph_s periph,
	input  wire logic [PORT_W-1:0]    odMask,
	input  wire logic                 pullEn,
	output gpp_pkg::gpp_pad_s         pad
);
	logic [PORT_W-1:0] drvVal;
	logic [PORT_W-1:0] drvOe;
	logic [PORT_W-1:0] odOe;

	always_comb
	begin
		drvVal = (periph.en & periph.dout) | (~periph.en & latch);
		drvOe  = (periph.en & periph.oe) | (~periph.en & ~dir);
		odOe   = drvOe & ~(odMask & drvVal);
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			pad <= '0;
		end
		else
		begin
			pad.dout <= drvVal & ~odMask;
			pad.oe   <= odOe;
			pad.pull <= {PORT_W{pullEn}} & ~drvOe;
		end
	end
endmodule : gpp_port

// File: design/gpp_apb_if.sv
`timescale 1ns/1ps
module gpp_apb_if
	import gpp_pkg::*;
(
	input  wire logic                  core_clk,
	input  wire logic                  rst_n,
	input  wire gpp_pkg::gpp_apb_req_s req,
	input  wire logic [PORT_W-1:0]     rdData,
	input  wire logic                  hit,
	output gpp_pkg::gpp_apb_rsp_s      rsp,
	output logic                       wrStb
);
	logic setup;

	assign setup = req.psel && !req.penable;
	// commit only on the edge that completes the access phase
	assign wrStb = req.psel && req.penable && req.pwrite && rsp.pready && hit;

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			rsp <= '0;
		end
		else if (setup)
		begin
			rsp.pready  <= 1'b1;
			rsp.pslverr <= !hit;
			rsp.prdata  <= (hit && !req.pwrite) ? {24'h000000, rdData} : 32'h00000000;
		end
		else
		begin
			rsp.pready  <= 1'b0;
			rsp.pslverr <= 1'b0;
			rsp.prdata  <= 32'h00000000;
		end
	end
endmodule : gpp_apb_if

// File: design/gpp_io_ports.sv
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
module gpp_io_ports
	import gpp_pkg::*;
(
	input  wire logic                  core_clk,
	input  wire logic                  rst_n,
	input  wire gpp_pkg::gpp_apb_req_s apbReq,
	output gpp_pkg::gpp_apb_rsp_s      apbRsp,
	input  wire logic [PORT_W-1:0]     padIn [NUM_PORTS],
	input  wire gpp_pkg::gpp_periph_s  periph [NUM_PORTS],
	output gpp_pkg::gpp_pad_s          pad [NUM_PORTS],
	output logic                       pmpTtlSel,
	output logic [PORT_W-1:0]          intCtrl2,
	output logic [PORT_W-1:0]          wdtCtrl,
	input  wire logic [PORT_W-1:0]     timerRdData [NUM_TIMER],
	output logic                       timerWr,
	output logic [1:0]                 timerIdx,
	output logic [PORT_W-1:0]          timerWdata
);
	logic [PORT_W-1:0] latch_r [NUM_PORTS];
	logic [PORT_W-1:0] dir_r [NUM_PORTS];
	logic [PORT_W-1:0] intCtrl2_r;
	logic [PORT_W-1:0] wdtCtrl_r;
	logic [2:0]        seventhPu_r;
	logic [PORT_W-1:0] odc1_r;
	logic [PORT_W-1:0] odc2_r;
	logic [PORT_W-1:0] odc3_r;
	logic [PORT_W-1:0] padCfg_r;
	logic              timerWr_r;
	logic [1:0]        timerIdx_r;
	logic [PORT_W-1:0] timerWdata_r;

	logic [PORT_W-1:0] rdData;
	logic              hit;
	logic              wrStb;
	logic [PORT_W-1:0] wData;
	logic [ADDR_W-1:0] addr;
	logic              sharedSel;
	logic              levelHit;
	logic              latchHit;
	logic              dirHit;
	logic [3:0]        levelIdx;
	logic [3:0]        latchIdx;
	logic [3:0]        dirIdx;
	logic              shHit;
	logic [1:0]        shIdx;
	logic [NUM_OD-1:0] odBits;
	logic              pullEn [NUM_PORTS];
	logic [PORT_W-1:0] odMask [NUM_PORTS];
	logic              intCtrl2Hit;
	logic              wdtCtrlHit;
	logic              cfgWr;
	logic              timerFwd;

	// address lies in a per-port bank on a word boundary
	function automatic logic inBank(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
		return (a >= base) && (a < base + BANK_SPAN) && (a[1:0] == 2'b00);
	endfunction : inBank

	function automatic logic [3:0] bankIdx(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] base);
		logic [ADDR_W-1:0] diff;
		diff = a - base;
		return diff[5:2];
	endfunction : bankIdx

	// per-pin open-drain mask of one port
	function automatic logic [PORT_W-1:0] odMaskFor(input int p, input logic [NUM_OD-1:0] od);
		logic [PORT_W-1:0] m;
		m = '0;
		for (int i = 0; i < NUM_OD; i++)
		begin
			if (OD_PORT[i] == p)
			begin
				m[OD_BIT[i]] = m[OD_BIT[i]] | od[i];
			end
		end
		return m;
	endfunction : odMaskFor

	assign addr      = apbReq.paddr;
	assign wData     = apbReq.pwdata[PORT_W-1:0];
	assign sharedSel = wdtCtrl_r[SHARED_SEL_BIT];
	assign levelHit  = inBank(addr, LEVEL_BASE);
	assign latchHit  = inBank(addr, LATCH_BASE);
	assign dirHit    = inBank(addr, DIR_BASE);
	assign levelIdx  = bankIdx(addr, LEVEL_BASE);
	assign latchIdx  = bankIdx(addr, LATCH_BASE);
	assign dirIdx    = bankIdx(addr, DIR_BASE);
	assign intCtrl2Hit = (addr == INT_CTRL2);
	assign wdtCtrlHit  = (addr == WDT_CTRL);
	// shared addresses follow the select bit as it stands at this access
	assign cfgWr       = wrStb && shHit && sharedSel;
	assign timerFwd    = wrStb && shHit && !sharedSel;

	always_comb
	begin
		shHit = 1'b1;
		shIdx = 2'd0;
		unique case (addr)
			SH_ODC1:   shIdx = 2'd0;
			SH_ODC2:   shIdx = 2'd1;
			SH_ODC3:   shIdx = 2'd2;
			SH_PADCFG: shIdx = 2'd3;
			default:   shHit = 1'b0;
		endcase
	end

	// read path and address decode
	always_comb
	begin
		rdData = '0;
		hit    = 1'b1;
		if (levelHit)
		begin
			rdData = padIn[levelIdx];
			if (levelIdx == 4'(PORT_G))
			begin
				rdData[SEVENTH_PU_HI:SEVENTH_PU_LO] = seventhPu_r;
			end
		end
		else if (latchHit)
		begin
			rdData = latch_r[latchIdx];
		end
		else if (dirHit)
		begin
			rdData = dir_r[dirIdx];
		end
		else if (intCtrl2Hit)
		begin
			rdData = intCtrl2_r;
		end
		else if (wdtCtrlHit)
		begin
			rdData = wdtCtrl_r;
		end
		else if (shHit && !sharedSel)
		begin
			rdData = timerRdData[shIdx];
		end
		else if (shHit)
		begin
			unique case (shIdx)
				2'd0: rdData = odc1_r & ODC1_MASK;
				2'd1: rdData = odc2_r & ODC2_MASK;
				2'd2: rdData = odc3_r & ODC3_MASK;
				2'd3: rdData = padCfg_r & PADCFG_MASK;
			endcase
		end
		else
		begin
			hit = 1'b0;
		end
	end

	gpp_apb_if u_apb (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.req      (apbReq),
		.rdData   (rdData),
		.hit      (hit),
		.rsp      (apbRsp),
		.wrStb    (wrStb)
	);

	// output latches: written through either the level or the latch address
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			for (int k = 0; k < NUM_PORTS; k++)
			begin
				latch_r[k] <= LATCH_RST;
			end
		end
		else if (wrStb && levelHit)
		begin
			latch_r[levelIdx] <= wData;
		end
		else if (wrStb && latchHit)
		begin
			latch_r[latchIdx] <= wData;
		end
	end

	// direction registers, inputs after reset
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			for (int k = 0; k < NUM_PORTS; k++)
			begin
				dir_r[k] <= DIR_RST;
			end
		end
		else if (wrStb && dirHit)
		begin
			dir_r[dirIdx] <= wData;
		end
	end

	// pull-up enables of the second to fourth pull-up ports
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			seventhPu_r <= '0;
		end
		else if (wrStb && levelHit && levelIdx == 4'(PORT_G))
		begin
			seventhPu_r <= wData[SEVENTH_PU_HI:SEVENTH_PU_LO];
		end
	end

	// interrupt control two; bit 7 is the first pull-up port enable
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			intCtrl2_r <= CTRL_RST;
		end
		else if (wrStb && intCtrl2Hit)
		begin
			intCtrl2_r <= wData;
		end
	end

	// watchdog control holds the shared-register select
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			wdtCtrl_r <= CTRL_RST;
		end
		else if (wrStb && wdtCtrlHit)
		begin
			wdtCtrl_r <= wData;
		end
	end

	// configuration registers behind the shared addresses
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			odc1_r   <= CTRL_RST;
			odc2_r   <= CTRL_RST;
			odc3_r   <= CTRL_RST;
			padCfg_r <= CTRL_RST;
		end
		else if (cfgWr)
		begin
			unique case (shIdx)
				2'd0: odc1_r   <= wData & ODC1_MASK;
				2'd1: odc2_r   <= wData & ODC2_MASK;
				2'd2: odc3_r   <= wData & ODC3_MASK;
				2'd3: padCfg_r <= wData & PADCFG_MASK;
			endcase
		end
	end

	// writes to shared addresses with select clear go to the timers
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			timerWr_r    <= 1'b0;
			timerIdx_r   <= 2'd0;
			timerWdata_r <= '0;
		end
		else
		begin
			timerWr_r <= timerFwd;
			if (timerFwd)
			begin
				timerIdx_r   <= shIdx;
				timerWdata_r <= wData;
			end
		end
	end

	// open-drain enables in pin-map order
	assign odBits = {odc3_r[1:0], odc2_r[1:0], odc1_r[4:0]};

	always_comb
	begin
		for (int k = 0; k < NUM_PORTS; k++)
		begin
			pullEn[k] = 1'b0;
		end
		pullEn[PORT_B] = intCtrl2_r[FIRST_PU_BIT];
		pullEn[PORT_D] = seventhPu_r[2];
		pullEn[PORT_E] = seventhPu_r[1];
		pullEn[PORT_J] = seventhPu_r[0];
	end

	// open-drain mask of each port from the pin map
	always_comb
	begin
		for (int k = 0; k < NUM_PORTS; k++)
		begin
			odMask[k] = odMaskFor(k, odBits);
		end
	end

	for (genvar k = 0; k < NUM_PORTS; k++)
	begin : g_port
		gpp_port u_port (
			.core_clk (core_clk),
			.rst_n    (rst_n),
			.dir      (dir_r[k]),
			.latch    (latch_r[k]),
			.periph   (periph[k]),
			.odMask   (odMask[k]),
			.pullEn   (pullEn[k]),
			.pad      (pad[k])
		);
	end

	assign pmpTtlSel  = padCfg_r[PAD_TTL_BIT];
	assign intCtrl2   = intCtrl2_r;
	assign wdtCtrl    = wdtCtrl_r;
	assign timerWr    = timerWr_r;
	assign timerIdx   = timerIdx_r;
	assign timerWdata = timerWdata_r;
endmodule : gpp_io_ports

// File: test/gpp_board.sv
`timescale 1ns/1ps
module gpp_board
	import gpp_pkg::*;
(
	input  wire gpp_pkg::gpp_pad_s pad    [NUM_PORTS],
	input  wire logic [PORT_W-1:0] extEn  [NUM_PORTS],
	input  wire logic [PORT_W-1:0] extLvl [NUM_PORTS],
	output logic [PORT_W-1:0]      padIn  [NUM_PORTS]
);
	always_comb
	begin
		for (int k = 0; k < NUM_PORTS; k++)
			// released pins float up through the board resistor
			padIn[k] = (pad[k].oe & pad[k].dout) | (~pad[k].oe & ~(extEn[k] & ~extLvl[k]));
	end
endmodule : gpp_board

// File: test/gpp_props.sv
`timescale 1ns/1ps
module gpp_props
	import gpp_pkg::*;
(
	input wire logic                  core_clk,
	input wire logic                  rst_n,
	input wire gpp_pkg::gpp_apb_req_s apbReq,
	input wire gpp_pkg::gpp_apb_rsp_s apbRsp,
	input wire logic [PORT_W-1:0]     padIn [NUM_PORTS],
	input wire gpp_pkg::gpp_periph_s  periph [NUM_PORTS],
	input wire gpp_pkg::gpp_pad_s     pad [NUM_PORTS],
	input wire logic                  pmpTtlSel,
	input wire logic [PORT_W-1:0]     intCtrl2,
	input wire logic                  timerWr,
	input wire logic [1:0]            timerIdx,
	input wire logic [PORT_W-1:0]     timerWdata,
	input wire logic [PORT_W-1:0]     wdtCtrl
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	wire setupE = apbReq.psel && !apbReq.penable;
	wire commit = apbReq.psel && apbReq.penable && apbRsp.pready && apbReq.pwrite;

	pready_one_wait_a: assert property (setupE |=> apbRsp.pready ##1 !apbRsp.pready)
		else $error("pready not one cycle after setup");
	timer_pulse_a: assert property (timerWr |=> !timerWr)
		else $error("timer write not a single pulse");
	reset_schmitt_a: assert property ($rose(rst_n) |-> !pmpTtlSel && wdtCtrl == CTRL_RST)
		else $error("buffer select or bank select not clear after reset");
	level_read_a: assert property (setupE && !apbReq.pwrite
		&& apbReq.paddr == LEVEL_BASE + 12'h010
		|=> apbRsp.prdata == {24'h0, $past(padIn[PORT_E])})
		else $error("level read differs from pins");
	unmapped_err_a: assert property (setupE && apbReq.paddr == 12'h100
		|=> apbRsp.pslverr && apbRsp.prdata == 32'h0)
		else $error("unmapped access not refused");
	timer_route_a: assert property (commit && apbReq.paddr == SH_PADCFG
		&& !wdtCtrl[SHARED_SEL_BIT] |=> timerWr && timerIdx == 2'h3
		&& timerWdata == $past(apbReq.pwdata[7:0]) && $stable(pmpTtlSel))
		else $error("shared write not routed to timer");
	pad_cfg_route_a: assert property (commit && apbReq.paddr == SH_PADCFG
		&& wdtCtrl[SHARED_SEL_BIT] |=> !timerWr
		&& pmpTtlSel == $past(apbReq.pwdata[PAD_TTL_BIT]))
		else $error("shared write not routed to pad config");
	periph_owns_a: assert property (periph[PORT_E].en == 8'hff
		|=> pad[PORT_E].oe == $past(periph[PORT_E].oe)
		&& ((pad[PORT_E].dout ^ $past(periph[PORT_E].dout)) & pad[PORT_E].oe) == 8'h00)
		else $error("peripheral does not own pins");
	pull_undriven_a: assert property ((pad[PORT_E].pull & pad[PORT_E].oe) == 8'h00)
		else $error("pull-up on a driven pin");
	pull_bit_a: assert property (commit && apbReq.paddr == INT_CTRL2
		|=> intCtrl2[FIRST_PU_BIT] == $past(apbReq.pwdata[FIRST_PU_BIT]))
		else $error("pull-up bit not written");

	cover property (commit && apbReq.paddr == SH_PADCFG && wdtCtrl[SHARED_SEL_BIT]);
	cover property (timerWr);
	cover property (apbRsp.pslverr);
endmodule : gpp_props

bind gpp_io_ports gpp_props i_props (.core_clk, .rst_n, .apbReq, .apbRsp, .padIn, .periph,
	.pad, .pmpTtlSel, .intCtrl2, .timerWr, .timerIdx, .timerWdata, .wdtCtrl);

// File: test/gpp_io_ports_tb.sv
`timescale 1ns/1ps
module gpp_io_ports_tb
	import gpp_pkg::*;
;
	localparam logic [7:0] MSK [4]  = '{ODC1_MASK, ODC2_MASK, ODC3_MASK, PADCFG_MASK};
	localparam logic [7:0] PULL [9] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'hf0, 8'h00, 8'h00, 8'h00,
		8'hff};
	logic                 core_clk = 1'b0;
	logic                 rst_n    = 1'b0;
	gpp_apb_req_s         apbReq   = '0;
	gpp_apb_rsp_s         apbRsp;
	logic [PORT_W-1:0]    padIn  [NUM_PORTS];
	gpp_periph_s          periph [NUM_PORTS];
	gpp_pad_s             pad    [NUM_PORTS];
	logic [PORT_W-1:0]    extEn  [NUM_PORTS];
	logic [PORT_W-1:0]    extLvl [NUM_PORTS];
	logic [PORT_W-1:0]    timerRdData [NUM_TIMER];
	logic                 pmpTtlSel;
	logic                 timerWr;
	logic [1:0]           timerIdx;
	logic [PORT_W-1:0]    timerWdata, intCtrl2, wdtCtrl;
	logic [31:0]          rdQ;
	logic                 rdE;
	int                   err_count = 0;
	int                   tests_run = 0;
	int                   cyc = 0;

	gpp_io_ports i_dut (.core_clk, .rst_n, .apbReq, .apbRsp, .padIn, .periph, .pad, .pmpTtlSel,
		.intCtrl2, .wdtCtrl, .timerRdData, .timerWr, .timerIdx, .timerWdata);
	gpp_board i_board (.pad, .extEn, .extLvl, .padIn);

	always #2.5 core_clk = ~core_clk;

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test

	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_count++;
			finish_test();
		end
	end

	task automatic check(input string nm, input logic [32:0] got, input logic [32:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch %s exp %h got %h", nm, exp, got);
		end
	endtask : check

	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge core_clk);
		apbReq <= '{1'b1, 1'b0, w, a, {24'h0, d}};
		@(posedge core_clk);
		apbReq.penable <= 1'b1;
		do
			@(posedge core_clk);
		while (apbRsp.pready !== 1'b1);
		rdQ = apbRsp.prdata;
		rdE = apbRsp.pslverr;
		apbReq <= '0;
	endtask : xfer

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [7:0] exp, input logic err = 1'b0);
		xfer(1'b0, a, 8'h00);
		check($sformatf("rd %h", a), {rdE, rdQ}, {err, 24'h0, exp});
	endtask : rd

	initial
	begin
		for (int k = 0; k < NUM_PORTS; k++)
		begin
			extEn[k]  = (k == PORT_C) ? 8'h00 : 8'hff;
			extLvl[k] = 8'h3c;
			periph[k] <= '0;
		end
		for (int k = 0; k < NUM_TIMER; k++)
			timerRdData[k] <= 8'ha0 + 8'(k);
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(DIR_BASE + 12'h020, DIR_RST);
		rd(LATCH_BASE, LATCH_RST);
		wr(WDT_CTRL, 8'h10);
		for (int k = 0; k < 4; k++)
			rd(SH_ODC1 + 12'(4 * k), CTRL_RST);
		check("ttl", {32'h0, pmpTtlSel}, 33'h0);
		for (int k = 0; k < 4; k++)
		begin
			wr(SH_ODC1 + 12'(4 * k), 8'hff);
			rd(SH_ODC1 + 12'(4 * k), MSK[k]);
		end
		check("ttl", {32'h0, pmpTtlSel}, 33'h1);
		for (int k = 0; k < 4; k++)
			wr(SH_ODC1 + 12'(4 * k), 8'h00);
		$display("test config done");
		wr(WDT_CTRL, 8'h00);
		rd(SH_ODC1, 8'ha0);
		rd(SH_PADCFG, 8'ha3);
		wr(SH_PADCFG, 8'h5b);
		@(posedge core_clk);
		check("tmr", {22'h0, timerWr, timerIdx, timerWdata}, {22'h0, 1'b1, 2'h3, 8'h5b});
		wr(WDT_CTRL, 8'h10);
		rd(WDT_CTRL, 8'h10);
		check("wdt", {25'h0, wdtCtrl}, 33'h010);
		rd(SH_PADCFG, 8'h00);
		$display("test shared done");
		wr(LATCH_BASE + 12'h010, 8'ha5);
		rd(LATCH_BASE + 12'h010, 8'ha5);
		rd(LEVEL_BASE + 12'h010, 8'h3c);
		wr(DIR_BASE + 12'h010, 8'hf0);
		rd(LEVEL_BASE + 12'h010, 8'h35);
		wr(LEVEL_BASE + 12'h010, 8'h0a);
		rd(LATCH_BASE + 12'h010, 8'h0a);
		rd(LEVEL_BASE + 12'h010, 8'h3a);
		check("oe e", {25'h0, pad[PORT_E].oe}, 33'h00f);
		periph[PORT_E] <= '{8'hff, 8'h33, 8'h0f};
		rd(LEVEL_BASE + 12'h010, 8'h33);
		periph[PORT_E] <= '0;
		$display("test port done");
		periph[PORT_C] <= '{8'h40, 8'h40, 8'h40};
		wr(DIR_BASE + 12'h008, 8'h00);
		wr(LATCH_BASE + 12'h008, 8'hff);
		rd(LEVEL_BASE + 12'h008, 8'hff);
		check("oe c", {25'h0, pad[PORT_C].oe}, 33'h0ff);
		wr(SH_ODC1, 8'h01);
		wr(SH_ODC2, 8'h01);
		rd(LEVEL_BASE + 12'h008, 8'hff);
		check("oe c", {25'h0, pad[PORT_C].oe}, 33'h0bb);
		wr(LATCH_BASE + 12'h008, 8'h00);
		rd(LEVEL_BASE + 12'h008, 8'h40);
		$display("test open drain done");
		wr(INT_CTRL2, 8'h80);
		rd(INT_CTRL2, 8'h80);
		check("int2", {25'h0, intCtrl2}, 33'h080);
		wr(LEVEL_BASE + 12'h018, 8'he0);
		rd(LEVEL_BASE + 12'h018, 8'hfc);
		for (int k = 0; k < NUM_PORTS; k++)
			check("pull", {25'h0, pad[k].pull}, {25'h0, PULL[k]});
		wr(12'h100, 8'h55);
		rd(12'h100, 8'h00, 1'b1);
		$display("test pull and unmapped done");
		finish_test();
	end
endmodule : gpp_io_ports_tb
